// >>> hw/dbd_params.svh
`ifndef DBD_PARAMS_SVH
`define DBD_PARAMS_SVH
// What this block does
// - Byte count keeps low 16 bits only
// - Active count decrements per completed write
// - Count write alone arms its descriptor
// - Flag free descriptor when second buffer starts
// - Zero count at trigger keeps channel stalled
// - Count write copies source base to pointer
// - Count write copies destination base to pointer
// - Pointers keep post-incremented values, read-only
// - Summary bits are plain OR, no storage
// - Summary bit map with swapped peripheral pairs
// - Summary register ignores writes
// - Swap bit resets to zero, peripherals first
// - Swap bit one gives memory channels priority
// - Free indicator: one on count0, zero on count1
// - Count write clears its terminal count flag

////////////////////////////////////////////////////////////////
// Register offsets, channel ones relative to the channel base
`define DBD_CTRL_OFS 32'h0000_0000
`define DBD_STAT_OFS 32'h0000_000C
`define DBD_BC0_OFS 32'h0000_0010
`define DBD_BC1_OFS 32'h0000_0014
`define DBD_SB0_OFS 32'h0000_0018
`define DBD_SB1_OFS 32'h0000_001C
`define DBD_SP0_OFS 32'h0000_0024
`define DBD_SP1_OFS 32'h0000_0028
`define DBD_DB0_OFS 32'h0000_002C
`define DBD_DB1_OFS 32'h0000_0030
`define DBD_DP1_OFS 32'h0000_003C
`define DBD_DP0_OFS 32'h0000_0044
`define DBD_ARB_ADDR 32'h8000_0380
`define DBD_GIRQ_ADDR 32'h8000_03C0

////////////////////////////////////////////////////////////////
// Field positions, widths and reset values
`define DBD_BC_W 16
`define DBD_CTRL_EN 0
`define DBD_CTRL_START 1
`define DBD_ST_STALL 0
`define DBD_ST_CH_LSB 1
`define DBD_ST_BUF_LSB 4
`define DBD_ST_DONE 6
`define DBD_ST_TC_LSB 7
`define DBD_ST_NFB 11
`define DBD_ST_NB 12
`define DBD_IRQ_NFB 0
`define DBD_IRQ_DONE 1
`define DBD_SWAP_RST 1'b0
`define DBD_M2P_NUM 10
`define DBD_M2M_NUM 2
`define DBD_SUM_W 12

`endif

// >>> hw/dbd_pkg.sv
package dbd_pkg;
    // Channel control states
    typedef enum logic [2:0] {
        DBD_IDLE = 3'b000,
        DBD_STALL = 3'b001,
        DBD_MEM_RD = 3'b010,
        DBD_MEM_WR = 3'b011
    } dbd_ch_t;
    // Descriptor pair states
    typedef enum logic [1:0] {
        DBD_NO_BUF = 2'b00,
        DBD_BUF_ON = 2'b01,
        DBD_BUF_NEXT = 2'b10
    } dbd_buf_t;
    // Current owner of the memory bus
    typedef enum logic [1:0] {
        DBD_OWN_NONE = 2'b00,
        DBD_OWN_M2P = 2'b01,
        DBD_OWN_M2M = 2'b10
    } dbd_own_t;
endpackage : dbd_pkg

// >>> hw/dbd_arb.sv
`include "dbd_params.svh"
module dbd_arb (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic swap_i,
    input wire logic m2p_req_i,
    input wire logic m2m_req_i,
    input wire logic m2p_rel_i,
    input wire logic m2m_rel_i,
    output logic m2p_gnt_o,
    output logic m2m_gnt_o
);
    import dbd_pkg::*;
    dbd_own_t own_ff;

    // Grant held until released, priority judged per new grant
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            own_ff <= DBD_OWN_NONE;
        end else begin
            case (own_ff)
                DBD_OWN_NONE: begin
                    if (m2p_req_i && m2m_req_i) begin
                        own_ff <= swap_i ? DBD_OWN_M2M : DBD_OWN_M2P;
                    end else if (m2p_req_i) begin
                        own_ff <= DBD_OWN_M2P;
                    end else if (m2m_req_i) begin
                        own_ff <= DBD_OWN_M2M;
                    end
                end
                DBD_OWN_M2P: if (m2p_rel_i) own_ff <= DBD_OWN_NONE;
                DBD_OWN_M2M: if (m2m_rel_i) own_ff <= DBD_OWN_NONE;
                default: own_ff <= DBD_OWN_NONE;
            endcase
        end
    end

    assign m2p_gnt_o = (own_ff == DBD_OWN_M2P);
    assign m2m_gnt_o = (own_ff == DBD_OWN_M2M);

    ////////////////////////////////////////////////////////////
    // Checks
    property p_prio_m2p;
        @(posedge mclk_i) disable iff (!nrst_i)
        (own_ff == DBD_OWN_NONE && m2p_req_i && m2m_req_i && !swap_i)
        |=> m2p_gnt_o && !m2m_gnt_o;
    endproperty
    a_prio_m2p: assert property (p_prio_m2p)
        else $error("peripheral channel lost default priority");
    property p_prio_m2m;
        @(posedge mclk_i) disable iff (!nrst_i)
        (own_ff == DBD_OWN_NONE && m2p_req_i && m2m_req_i && swap_i)
        |=> m2m_gnt_o && !m2p_gnt_o;
    endproperty
    a_prio_m2m: assert property (p_prio_m2m)
        else $error("memory channel lost swapped priority");
    property p_cv_swap;
        @(posedge mclk_i) disable iff (!nrst_i)
        swap_i && m2p_req_i && m2m_req_i && own_ff == DBD_OWN_NONE;
    endproperty
    c_cv_swap: cover property (p_cv_swap);
endmodule : dbd_arb

// >>> hw/dbd_irq_sum.sv
`include "dbd_params.svh"
module dbd_irq_sum #(
    parameter int IW = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [`DBD_M2P_NUM*IW-1:0] m2p_irq_i,
    input wire logic [`DBD_M2M_NUM*IW-1:0] m2m_irq_i,
    output logic [`DBD_SUM_W-1:0] sum_o
);
    // Peripheral bits swap in pairs, memory bits follow
    for (genvar g = 0; g < `DBD_SUM_W; g++) begin : g_bit
        if (g < `DBD_M2P_NUM) begin : g_p
            assign sum_o[g] = |m2p_irq_i[(g ^ 1)*IW +: IW];
        end else begin : g_m
            assign sum_o[g] =
                |m2m_irq_i[(g - `DBD_M2P_NUM)*IW +: IW];
        end
    end

    property p_or_m2m1;
        @(posedge mclk_i) disable iff (!nrst_i)
        sum_o[11] == (|m2m_irq_i[IW +: IW]);
    endproperty
    a_or_m2m1: assert property (p_or_m2m1)
        else $error("summary bit 11 does not follow memory channel 1");
    property p_or_m2p0;
        @(posedge mclk_i) disable iff (!nrst_i)
        ($fell(|m2p_irq_i[0 +: IW])) |-> !sum_o[1];
    endproperty
    a_or_m2p0: assert property (p_or_m2p0)
        else $error("summary bit 1 stored after channel 0 cleared");
endmodule : dbd_irq_sum

// >>> hw/dbd_top.sv
// The implementer's own choice: the AHB-Lite slave port.
`include "dbd_params.svh"
module dbd_top #(
    parameter logic [31:0] CH_BASE = 32'h0000_0000,
    parameter int IW = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Byte-wide memory master port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // Peripheral channel side of the arbiter
    input wire logic m2p_req_i,
    input wire logic m2p_rel_i,
    output logic m2p_gnt_o,
    // Interrupt registers of the other channels
    input wire logic [`DBD_M2P_NUM*IW-1:0] m2p_irq_i,
    input wire logic [IW-1:0] m2m1_irq_i,
    output logic nfb_o
);
    import dbd_pkg::*;

    ////////////////////////////////////////////////////////////
    // Bus address phase capture
    logic vld_ff;
    logic wr_ff;
    logic [31:0] adr_ff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vld_ff <= 1'b0;
            wr_ff <= 1'b0;
            adr_ff <= 32'h0000_0000;
        end else if (hready_i) begin
            vld_ff <= hsel_i && htrans_i[1];
            wr_ff <= hwrite_i;
            adr_ff <= haddr_i;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Write strobes of the data phase
    logic we;
    logic [1:0] wr_bc;
    logic [1:0] wr_sb;
    logic [1:0] wr_db;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_arb;

    assign we = vld_ff && wr_ff;
    assign wr_bc[0] = we && adr_ff == CH_BASE + `DBD_BC0_OFS;
    assign wr_bc[1] = we && adr_ff == CH_BASE + `DBD_BC1_OFS;
    assign wr_sb[0] = we && adr_ff == CH_BASE + `DBD_SB0_OFS;
    assign wr_sb[1] = we && adr_ff == CH_BASE + `DBD_SB1_OFS;
    assign wr_db[0] = we && adr_ff == CH_BASE + `DBD_DB0_OFS;
    assign wr_db[1] = we && adr_ff == CH_BASE + `DBD_DB1_OFS;
    assign wr_ctrl = we && adr_ff == CH_BASE + `DBD_CTRL_OFS;
    assign wr_stat = we && adr_ff == CH_BASE + `DBD_STAT_OFS;
    assign wr_arb = we && adr_ff == `DBD_ARB_ADDR;

    ////////////////////////////////////////////////////////////
    // Control and arbitration bits
    logic en_ff;
    logic start_ff;
    logic swap_ff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_ff <= 1'b0;
            start_ff <= 1'b0;
        end else if (wr_ctrl) begin
            en_ff <= hwdata_i[`DBD_CTRL_EN];
            start_ff <= hwdata_i[`DBD_CTRL_START];
        end
    end

    // Only bit 0 is stored, rest ignored
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            swap_ff <= `DBD_SWAP_RST;
        end else if (wr_arb) begin
            swap_ff <= hwdata_i[0];
        end
    end

    ////////////////////////////////////////////////////////////
    // Channel state shared with the descriptors
    dbd_ch_t ch_ff;
    dbd_buf_t buf_ff;
    logic act_ff;
    logic [7:0] dat_ff;
    logic rd_ack;
    logic wr_ack;
    logic fin;
    logic [`DBD_BC_W-1:0] bc_ff [2];
    logic [31:0] sb_ff [2];
    logic [31:0] db_ff [2];
    logic [31:0] sp_ff [2];
    logic [31:0] dp_ff [2];
    logic [1:0] tc_ff;

    assign rd_ack = ch_ff == DBD_MEM_RD && mem_ack_i;
    assign wr_ack = ch_ff == DBD_MEM_WR && mem_ack_i;
    assign fin = wr_ack && bc_ff[act_ff] == `DBD_BC_W'(1);

    // One descriptor per entry
    for (genvar d = 0; d < 2; d++) begin : g_desc
        logic mine;
        assign mine = act_ff == 1'(d);

        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                sb_ff[d] <= 32'h0000_0000;
                db_ff[d] <= 32'h0000_0000;
            end else begin
                if (wr_sb[d]) sb_ff[d] <= hwdata_i;
                if (wr_db[d]) db_ff[d] <= hwdata_i;
            end
        end

        // Software reload wins over a decrement
        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                bc_ff[d] <= '0;
            end else if (wr_bc[d]) begin
                bc_ff[d] <= hwdata_i[`DBD_BC_W-1:0];
            end else if (wr_ack && mine) begin
                bc_ff[d] <= bc_ff[d] - `DBD_BC_W'(1);
            end
        end

        // Pointers load from bases, then post-increment
        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                sp_ff[d] <= 32'h0000_0000;
                dp_ff[d] <= 32'h0000_0000;
            end else if (wr_bc[d]) begin
                sp_ff[d] <= sb_ff[d];
                dp_ff[d] <= db_ff[d];
            end else begin
                if (rd_ack && mine) sp_ff[d] <= sp_ff[d] + 32'h1;
                if (wr_ack && mine) dp_ff[d] <= dp_ff[d] + 32'h1;
            end
        end

        // Terminal count per descriptor
        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                tc_ff[d] <= 1'b0;
            end else if (wr_bc[d]) begin
                tc_ff[d] <= 1'b0;
            end else if (fin && mine) begin
                tc_ff[d] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Descriptor pair state and active buffer
    logic nb_ff;
    logic nfb_ff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buf_ff <= DBD_NO_BUF;
            act_ff <= 1'b0;
            nfb_ff <= 1'b0;
        end else begin
            nfb_ff <= 1'b0;
            case (buf_ff)
                DBD_NO_BUF: begin
                    if (|wr_bc) begin
                        buf_ff <= DBD_BUF_ON;
                        act_ff <= wr_bc[1];
                    end
                end
                DBD_BUF_ON: begin
                    // Arming on the very last byte still chains
                    if (fin && wr_bc[~act_ff]) begin
                        act_ff <= ~act_ff;
                        nfb_ff <= 1'b1;
                    end else if (fin && !wr_bc[act_ff]) begin
                        buf_ff <= DBD_NO_BUF;
                    end else if (wr_bc[~act_ff]) begin
                        buf_ff <= DBD_BUF_NEXT;
                    end
                end
                DBD_BUF_NEXT: begin
                    if (fin) begin
                        buf_ff <= DBD_BUF_ON;
                        act_ff <= ~act_ff;
                        nfb_ff <= 1'b1;
                    end
                end
                default: buf_ff <= DBD_NO_BUF;
            endcase
        end
    end

    // Tells software which descriptor is free
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nb_ff <= 1'b0;
        end else if (wr_bc[0]) begin
            nb_ff <= 1'b1;
        end else if (wr_bc[1]) begin
            nb_ff <= 1'b0;
        end
    end

    assign nfb_o = nfb_ff;

    ////////////////////////////////////////////////////////////
    // Channel control machine, one byte per grant
    logic go;
    logic m2m_gnt;
    logic m2m_req;
    logic m2m_rel;

    // Zero count never leaves stall
    assign go = en_ff && start_ff && buf_ff != DBD_NO_BUF &&
        bc_ff[act_ff] != '0;
    assign m2m_req = ch_ff == DBD_STALL && go;
    assign m2m_rel = wr_ack || (m2m_gnt && !(ch_ff == DBD_MEM_RD) &&
        !(ch_ff == DBD_MEM_WR) && !m2m_req);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ch_ff <= DBD_IDLE;
        end else if (!en_ff) begin
            ch_ff <= DBD_IDLE;
        end else begin
            case (ch_ff)
                DBD_IDLE: ch_ff <= DBD_STALL;
                DBD_STALL: if (m2m_req && m2m_gnt) ch_ff <= DBD_MEM_RD;
                DBD_MEM_RD: if (mem_ack_i) ch_ff <= DBD_MEM_WR;
                DBD_MEM_WR: if (mem_ack_i) ch_ff <= DBD_STALL;
                default: ch_ff <= DBD_IDLE;
            endcase
        end
    end

    // Byte held between read and write
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dat_ff <= 8'h00;
        end else if (rd_ack) begin
            dat_ff <= mem_rdata_i;
        end
    end

    // Source feeds reads, destination takes writes
    assign mem_req_o = ch_ff == DBD_MEM_RD || ch_ff == DBD_MEM_WR;
    assign mem_we_o = ch_ff == DBD_MEM_WR;
    assign mem_addr_o = mem_we_o ? dp_ff[act_ff] :
        sp_ff[act_ff];
    assign mem_wdata_o = dat_ff;

    dbd_arb u_arb (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .swap_i(swap_ff),
        .m2p_req_i(m2p_req_i),
        .m2m_req_i(m2m_req),
        .m2p_rel_i(m2p_rel_i),
        .m2m_rel_i(m2m_rel),
        .m2p_gnt_o(m2p_gnt_o),
        .m2m_gnt_o(m2m_gnt)
    );

    ////////////////////////////////////////////////////////////
    // Own interrupt flags, set beats a status write
    logic nfb_flag_ff;
    logic done_flag_ff;
    logic [IW-1:0] own_irq;
    logic [`DBD_SUM_W-1:0] sum;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nfb_flag_ff <= 1'b0;
            done_flag_ff <= 1'b0;
        end else begin
            nfb_flag_ff <= nfb_ff || (nfb_flag_ff && !wr_stat);
            done_flag_ff <= fin || (done_flag_ff && !wr_stat);
        end
    end

    always_comb begin
        own_irq = '0;
        own_irq[`DBD_IRQ_NFB] = nfb_flag_ff;
        own_irq[`DBD_IRQ_DONE] = done_flag_ff;
    end

    dbd_irq_sum #(.IW(IW)) u_sum (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .m2p_irq_i(m2p_irq_i),
        .m2m_irq_i({m2m1_irq_i, own_irq}),
        .sum_o(sum)
    );

    ////////////////////////////////////////////////////////////
    // Read data, reserved and unmapped read zero
    logic [31:0] stat;

    always_comb begin
        stat = 32'h0000_0000;
        stat[`DBD_ST_STALL] = ch_ff == DBD_STALL;
        stat[`DBD_ST_CH_LSB +: 3] = ch_ff;
        stat[`DBD_ST_BUF_LSB +: 2] = buf_ff;
        stat[`DBD_ST_DONE] = done_flag_ff;
        stat[`DBD_ST_TC_LSB +: 2] = tc_ff;
        stat[`DBD_ST_NFB] = nfb_flag_ff;
        stat[`DBD_ST_NB] = nb_ff;
    end

    always_comb begin
        hrdata_o = 32'h0000_0000;
        if (vld_ff && !wr_ff) begin
            case (adr_ff)
                CH_BASE + `DBD_CTRL_OFS:
                    hrdata_o[1:0] = {start_ff, en_ff};
                CH_BASE + `DBD_STAT_OFS: hrdata_o = stat;
                CH_BASE + `DBD_BC0_OFS: hrdata_o[15:0] = bc_ff[0];
                CH_BASE + `DBD_BC1_OFS: hrdata_o[15:0] = bc_ff[1];
                CH_BASE + `DBD_SB0_OFS: hrdata_o = sb_ff[0];
                CH_BASE + `DBD_SB1_OFS: hrdata_o = sb_ff[1];
                CH_BASE + `DBD_SP0_OFS: hrdata_o = sp_ff[0];
                CH_BASE + `DBD_SP1_OFS: hrdata_o = sp_ff[1];
                CH_BASE + `DBD_DB0_OFS: hrdata_o = db_ff[0];
                CH_BASE + `DBD_DB1_OFS: hrdata_o = db_ff[1];
                CH_BASE + `DBD_DP0_OFS: hrdata_o = dp_ff[0];
                CH_BASE + `DBD_DP1_OFS: hrdata_o = dp_ff[1];
                `DBD_ARB_ADDR: hrdata_o[0] = swap_ff;
                `DBD_GIRQ_ADDR: hrdata_o[11:0] = sum;
                default: hrdata_o = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    property p_bc_load;
        wr_bc[0] |=> bc_ff[0] == $past(hwdata_i[15:0]);
    endproperty
    a_bc_load: assert property (p_bc_load)
        else $error("count 0 not loaded from bus");
    property p_sp_copy;
        wr_bc[1] |=> sp_ff[1] == $past(sb_ff[1]);
    endproperty
    a_sp_copy: assert property (p_sp_copy)
        else $error("source pointer 1 not loaded from base");
    property p_dp_copy;
        wr_bc[0] |=> dp_ff[0] == $past(db_ff[0]);
    endproperty
    a_dp_copy: assert property (p_dp_copy)
        else $error("destination pointer 0 not loaded from base");
    property p_dec;
        (wr_ack && !act_ff && !wr_bc[0]) |=>
            bc_ff[0] == $past(bc_ff[0]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec)
        else $error("count did not drop by one after a write");
    property p_nfb;
        (fin && buf_ff == DBD_BUF_NEXT) |=> nfb_o ##1 nfb_flag_ff;
    endproperty
    a_nfb: assert property (p_nfb)
        else $error("free descriptor not signalled");
    property p_zero_stall;
        (ch_ff == DBD_STALL && bc_ff[act_ff] == '0) |=>
            ch_ff != DBD_MEM_RD;
    endproperty
    a_zero_stall: assert property (p_zero_stall)
        else $error("transfer started with zero count");
    property p_nb;
        wr_bc[0] && !wr_bc[1] |=> nb_ff ##1 (nb_ff || $past(wr_bc[1]));
    endproperty
    a_nb: assert property (p_nb)
        else $error("free indicator not set by count 0 write");
    property p_tc;
        wr_bc[1] |=> !tc_ff[1];
    endproperty
    a_tc: assert property (p_tc)
        else $error("terminal count not cleared by write");
    property p_switch;
        (fin && buf_ff == DBD_BUF_NEXT) |=>
            act_ff != $past(act_ff) && buf_ff == DBD_BUF_ON;
    endproperty
    a_switch: assert property (p_switch)
        else $error("no switch to armed descriptor");
    property p_ptr_hold;
        (ch_ff == DBD_STALL && !(|wr_bc)) |=>
            sp_ff[0] == $past(sp_ff[0]);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold)
        else $error("source pointer moved while stalled");

    property p_cv_chain;
        fin && buf_ff == DBD_BUF_NEXT;
    endproperty
    c_cv_chain: cover property (p_cv_chain);
    property p_cv_rearm;
        buf_ff == DBD_BUF_ON ##1 wr_bc[~act_ff];
    endproperty
    c_cv_rearm: cover property (p_cv_rearm);
endmodule : dbd_top

// >>> bench/dbd_mem_model.sv
module dbd_mem_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic slow_i,
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    output logic [7:0] mem_rdata_o,
    output logic mem_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_ff;
    // One-cycle ack after zero or three wait cycles; data only with ack
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_ff <= 2'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 8'h00;
        end else if (mem_req_i && !mem_ack_o
                     && wait_ff == (slow_i ? 2'h3 : 2'h0)) begin
            wait_ff <= 2'h0;
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem_addr_i[7:0] ^ 8'h5A;
        end else begin
            wait_ff <= (mem_req_i && !mem_ack_o) ? wait_ff + 2'h1 : 2'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o; // Stale data never looks valid
        end
    end
endmodule : dbd_mem_model

// >>> bench/dma_buffer_descriptor_regs_bench.sv
module dma_buffer_descriptor_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, nrst, hsel, hwrite, hreadyout, m2p_req, m2p_rel, slow;
    logic mem_req, mem_we, mem_ack, m2p_gnt, next_buffer_free_irq, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, mem_addr, last_wa;
    logic [79:0] m2p_irq;
    logic [7:0] m2m1_irq, mem_rdata, mem_wdata, last_wd;
    int bad_count, compares, wr_n, nfb_n;
    dbd_top dut_u (.mclk_i(mclk), .nrst_i(nrst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
        .mem_ack_i(mem_ack), .m2p_req_i(m2p_req), .m2p_rel_i(m2p_rel),
        .m2p_gnt_o(m2p_gnt), .m2p_irq_i(m2p_irq), .m2m1_irq_i(m2m1_irq),
        .nfb_o(next_buffer_free_irq));
    dbd_mem_model mem_u (.mclk_i(mclk), .nrst_i(nrst), .slow_i(slow),
        .mem_req_i(mem_req), .mem_addr_i(mem_addr),
        .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));
    ////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Completed byte writes, alternating memory speed after each
    always @(posedge mclk) begin
        if (mem_req === 1'b1 && mem_we === 1'b1 && mem_ack === 1'b1) begin
            wr_n++;
            last_wa = mem_addr;
            last_wd = mem_wdata;
            slow <= ~slow;
        end
        if (next_buffer_free_irq === 1'b1) nfb_n++;
    end
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One single AHB-Lite word transfer, read data left in rd
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : bus
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task pulse_rel();
        m2p_rel <= 1'b1;
        @(posedge mclk);
        m2p_rel <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : pulse_rel
    ////////////////////////////////////////////////////////////////
    // Swap bit reset, reserved bits, summary map and write lockout
    task t_regs();
        rdchk(32'h8000_0380, 32'h0);
        bus(1'b1, 32'h8000_0380, 32'hFFFF_FFFE);
        rdchk(32'h8000_0380, 32'h0);
        for (int c = 0; c < 10; c++) begin
            m2p_irq <= 80'h1 << (c * 8 + 5);
            @(posedge mclk);
            rdchk(32'h8000_03C0, 32'h1 << (c ^ 1));
        end
        m2p_irq <= 80'h0;
        m2m1_irq <= 8'h01;
        @(posedge mclk);
        rdchk(32'h8000_03C0, 32'h800);
        bus(1'b1, 32'h8000_03C0, 32'hFFFF_FFFF);
        chk({31'h0, hresp}, 32'h0);
        rdchk(32'h8000_03C0, 32'h800);
        m2m1_irq <= 8'h00;
        @(posedge mclk);
        rdchk(32'h8000_03C0, 32'h0);
    endtask : t_regs
    // Two chained buffers, arbitration in both priority orders
    task t_dbl();
        bus(1'b1, 32'h18, 32'h100);
        bus(1'b1, 32'h2C, 32'h200);
        bus(1'b1, 32'h10, 32'h2);
        rdchk(32'h24, 32'h100);
        rdchk(32'h44, 32'h200);
        bus(1'b0, 32'hC, 32'h0);
        chk({31'h0, rd[12]}, 32'h1);
        m2p_req <= 1'b1;
        repeat (3) @(posedge mclk);
        bus(1'b1, 32'h0, 32'h3);
        pulse_rel();
        chk({30'h0, m2p_gnt, mem_req}, 32'h2);
        bus(1'b1, 32'h8000_0380, 32'h1);
        pulse_rel();
        chk({31'h0, m2p_gnt}, 32'h0);
        m2p_req <= 1'b0;
        // Second descriptor armed while the first one is moving data
        bus(1'b1, 32'h1C, 32'h300);
        bus(1'b1, 32'h30, 32'h400);
        bus(1'b1, 32'h14, 32'h1);
        bus(1'b0, 32'hC, 32'h0);
        chk({31'h0, rd[12]}, 32'h0);
        for (int i = 0; i < 100 && rd[8] !== 1'b1; i++) bus(1'b0, 32'hC, 0);
        chk({29'h0, rd[8:6]}, 32'h7);
        rdchk(32'h24, 32'h102);
        rdchk(32'h44, 32'h202);
        rdchk(32'h28, 32'h301);
        rdchk(32'h3C, 32'h401);
        rdchk(32'h10, 32'h0);
        rdchk(32'h14, 32'h0);
        chk(wr_n, 32'h3);
        chk({last_wd, last_wa[23:0]}, 32'h5A00_0400);
        chk(nfb_n, 32'h1);
    endtask : t_dbl
    // Zero count armed with the trigger still set, then own flags
    task t_zero();
        bus(1'b1, 32'h10, 32'hFFFF_0000);
        rdchk(32'h10, 32'h0);
        repeat (10) @(posedge mclk);
        bus(1'b0, 32'hC, 32'h0);
        chk({29'h0, rd[7], rd[3:2]}, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        chk({31'h0, mem_req}, 32'h0);
        chk(wr_n, 32'h3);
        bus(1'b1, 32'h8000_03C0, 32'hFFFF_FFFF);
        rdchk(32'h8000_03C0, 32'h400);
        bus(1'b1, 32'hC, 32'h0);
        rdchk(32'h8000_03C0, 32'h0);
    endtask : t_zero
    ////////////////////////////////////////////////////////////////
    task give_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // Watchdog
    initial begin
        #2000000;
        bad_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        {nrst, hsel, hwrite, m2p_req, m2p_rel, slow} = 6'h0;
        {htrans, haddr, hwdata, m2p_irq, m2m1_irq} = 0;
        rd = 32'h0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_dbl();
        t_zero();
        give_verdict();
    end
endmodule : dma_buffer_descriptor_regs_bench
